/* File: urbd_pkg.sv */
/*
 register bank constants for one uart channel front end: register
 indices, field positions, select keys and reset values.
 assumes a host bus with a three-bit register address.
*/
package urbd_pkg;
   localparam int         ADDR_W          = 3;
   localparam int         DATA_W          = 8;
   // register indices on the three-bit address
   localparam logic [2:0] IDX_0           = 3'h0;
   localparam logic [2:0] IDX_1           = 3'h1;
   localparam logic [2:0] IDX_2           = 3'h2;
   localparam logic [2:0] IDX_3           = 3'h3;
   localparam logic [2:0] IDX_4           = 3'h4;
   localparam logic [2:0] IDX_5           = 3'h5;
   localparam logic [2:0] IDX_6           = 3'h6;
   localparam logic [2:0] IDX_7           = 3'h7;
   // line control keys
   localparam int         LCR_DIV_BIT     = 7;
   localparam logic [7:0] LCR_ENH_KEY     = 8'hbf;
   localparam int         EFR_ENH_BIT     = 4;
   // mask bit positions
   localparam int         IM_RX           = 0;
   localparam int         IM_TX           = 1;
   localparam int         IM_LS           = 2;
   localparam int         IM_MS           = 3;
   localparam int         IM_XOFF         = 5;
   localparam int         IM_RTS          = 6;
   localparam int         IM_CTS          = 7;
   localparam int         FCR_FIFO_BIT    = 0;
   localparam logic [7:0] IM_LOW_MASK     = 8'h0f;
   localparam logic [7:0] DLD_MASK        = 8'h0f;
   localparam logic [7:0] AFR_MASK        = 8'h07;
   localparam logic [4:0] LSR_ERR_MASK    = 5'h1e;
   // source codes, bits 5:0 of the status register
   localparam logic [5:0] SRC_NONE        = 6'h01;
   localparam logic [5:0] SRC_LS          = 6'h06;
   localparam logic [5:0] SRC_RXTO        = 6'h0c;
   localparam logic [5:0] SRC_RX          = 6'h04;
   localparam logic [5:0] SRC_TX          = 6'h02;
   localparam logic [5:0] SRC_MS          = 6'h00;
   localparam logic [5:0] SRC_XOFF        = 6'h10;
   localparam logic [5:0] SRC_FLOW        = 6'h20;
   localparam logic [7:0] ZERO8           = 8'h00;
endpackage : urbd_pkg

/* File: urbd_if.sv */
/*
 carrier between the register bank and its interrupt encoder.
 assumes one clock domain; signals are plain levels.
*/
`timescale 1ns/1ps
interface urbd_if;
   logic [7:0] mask;        // effective mask, upper bits gated
   logic       rx_req;      // receive data condition
   logic       rxto_req;    // receive timeout
   logic       tx_req;      // transmit-ready latch
   logic       ls_req;      // line status error
   logic       ms_req;      // modem status change
   logic       xoff_req;    // xoff received
   logic       flow_req;    // cts/rts rise
   logic       fifo_on;     // fifo mode
   logic [7:0] source;      // encoded status value
   modport bank (output mask, rx_req, rxto_req, tx_req, ls_req, ms_req,
                 output xoff_req, flow_req, fifo_on, input source);
   modport enc  (input mask, rx_req, rxto_req, tx_req, ls_req, ms_req,
                 input xoff_req, flow_req, fifo_on, output source);
endinterface : urbd_if

/* File: urbd_int_enc.sv */
/*
 interrupt source encoder: gates each source with its mask bit and
 encodes the highest pending one.
 assumes inputs are registered levels on the same clock.
*/
`timescale 1ns/1ps
module urbd_int_enc (
   urbd_if.enc c
);
   logic [5:0] code;
   // fixed priority, line status highest
   always_comb begin
      code = urbd_pkg::SRC_NONE;
      if (c.ls_req && c.mask[urbd_pkg::IM_LS])
         code = urbd_pkg::SRC_LS;
      else if (c.rxto_req && c.mask[urbd_pkg::IM_RX])
         code = urbd_pkg::SRC_RXTO;
      else if (c.rx_req && c.mask[urbd_pkg::IM_RX])
         code = urbd_pkg::SRC_RX;
      else if (c.tx_req && c.mask[urbd_pkg::IM_TX])
         code = urbd_pkg::SRC_TX;
      else if (c.ms_req && c.mask[urbd_pkg::IM_MS])
         code = urbd_pkg::SRC_MS;
      else if (c.xoff_req && c.mask[urbd_pkg::IM_XOFF])
         code = urbd_pkg::SRC_XOFF;
      else if (c.flow_req && (c.mask[urbd_pkg::IM_RTS]
                              || c.mask[urbd_pkg::IM_CTS]))
         code = urbd_pkg::SRC_FLOW;
   end
   // fifo mode shows in the top two bits
   assign c.source = {c.fifo_on, c.fifo_on, code};
endmodule : urbd_int_enc

/* File: urbd_bank.sv */
/*
 register bank and interrupt mask front end of one uart channel.
 assumes host strobes are synchronous single-cycle pulses on sys_clk
 and that receiver/transmitter status comes from logic on that clock.
*/
`timescale 1ns/1ps
// What this block does
// - receive holding register is read-only
// - transmit holding register is write-only
// - mask gates the four basic sources
// - enabled sources reported in source register
// - divisor bytes at 0,1 when divisor bit set, except with line control 0xbf
// - mask bit 0 enables receive data interrupt
// - transmit interrupt fires if already empty
// - line status bits 1-4 raise interrupt
// - mask bits 7:4 need enhanced enable
module urbd_bank #(
   parameter logic [7:0] REV_CODE = 8'h01,   // arbitrary value
   parameter logic [7:0] ID_CODE  = 8'h5a    // arbitrary value
) (
   input  wire logic       sys_clk,
   input  wire logic       arst_n,
   input  wire logic [2:0] addr,
   input  wire logic       rd_stb,
   input  wire logic       wr_stb,
   input  wire logic [7:0] wr_data,
   output logic      [7:0] rd_data,
   output logic            tx_char_stb,
   output logic      [7:0] tx_char,
   output logic            rx_char_ack,
   input  wire logic [7:0] rx_char,
   input  wire logic       rx_avail,
   input  wire logic       rx_trig_hit,
   input  wire logic       rx_timeout,
   input  wire logic       tx_empty,
   input  wire logic [7:0] line_status_reg,
   input  wire logic [7:0] modem_status,
   input  wire logic       xoff_seen,
   input  wire logic       flow_rise,
   input  wire logic [7:0] fifo_level,
   input  wire logic [7:0] scratch_in,
   output logic            int_out,
   output logic      [7:0] divisor_out,
   output logic      [7:0] divisor_hi_out,
   output logic      [7:0] line_control_out,
   output logic      [7:0] enhanced_out,
   output logic      [7:0] mask_out,
   output logic      [7:0] trigger_out,
   output logic            trigger_stb,
   output logic      [7:0] fcr_out,
   output logic      [7:0] mcr_out
);
   urbd_if c ();

   logic [7:0] div_lo_reg, div_lo_next, div_hi_reg, div_hi_next;
   logic [7:0] lcr_reg, lcr_next, efr_reg, efr_next;
   logic [7:0] imask_reg, imask_next, afr_reg, afr_next;
   logic [7:0] dld_reg, dld_next, feature_control_reg, feature_control_next;
   logic [7:0] resume_char_one_reg, resume_char_one_next, resume_char_two_reg, resume_char_two_next;
   logic [7:0] pause_char_one_reg, pause_char_one_next, pause_char_two_reg, pause_char_two_next;
   logic [7:0] trg_reg, trg_next, fcr_reg, fcr_next;
   logic [7:0] mcr_reg, mcr_next, rdata_reg, rdata_next;
   logic [7:0] thr_reg, thr_next;
   logic       thr_stb_reg, thr_stb_next, rhr_ack_reg, rhr_ack_next;
   logic       trg_stb_reg, trg_stb_next;
   logic       txi_reg, txi_next, int_reg, int_next;
   logic       div_sel, enh_sel, efr_on, rd_isr, fifo_en;

   // access keys for shared offsets
   assign div_sel = lcr_reg[urbd_pkg::LCR_DIV_BIT];
   assign enh_sel = (lcr_reg == urbd_pkg::LCR_ENH_KEY);
   assign efr_on  = efr_reg[urbd_pkg::EFR_ENH_BIT];
   assign fifo_en = fcr_reg[urbd_pkg::FCR_FIFO_BIT];
   assign rd_isr  = rd_stb && (addr == urbd_pkg::IDX_2) && !div_sel
                    && !enh_sel;

   // feed the encoder; upper mask bits ignored without enhanced enable
   assign c.mask     = efr_on ? imask_reg
                       : (imask_reg & urbd_pkg::IM_LOW_MASK);
   assign c.rx_req   = fifo_en ? rx_trig_hit : rx_avail;
   assign c.rxto_req = fifo_en && rx_timeout;
   assign c.tx_req   = txi_reg;
   assign c.ls_req   = |(line_status_reg[4:0]
                         & urbd_pkg::LSR_ERR_MASK);
   assign c.ms_req   = |modem_status[3:0];
   assign c.xoff_req = xoff_seen;
   assign c.flow_req = flow_rise;
   assign c.fifo_on  = fifo_en;

   urbd_int_enc u_enc (
      .c (c)
   );

   // register writes, decoded by address and access keys
   always_comb begin
      div_lo_next  = div_lo_reg;
      div_hi_next  = div_hi_reg;
      lcr_next     = lcr_reg;
      efr_next     = efr_reg;
      imask_next   = imask_reg;
      afr_next     = afr_reg;
      dld_next     = dld_reg;
      feature_control_next    = feature_control_reg;
      resume_char_one_next    = resume_char_one_reg;
      resume_char_two_next    = resume_char_two_reg;
      pause_char_one_next   = pause_char_one_reg;
      pause_char_two_next   = pause_char_two_reg;
      trg_next     = trg_reg;
      fcr_next     = fcr_reg;
      mcr_next     = mcr_reg;
      thr_next     = thr_reg;
      thr_stb_next = 1'b0;
      trg_stb_next = 1'b0;
      if (wr_stb) begin
         if (enh_sel) begin
            unique case (addr)
               urbd_pkg::IDX_0: begin
                  trg_next     = wr_data;
                  trg_stb_next = 1'b1;
               end
               urbd_pkg::IDX_1: feature_control_next  = wr_data;
               urbd_pkg::IDX_2: efr_next   = wr_data;
               urbd_pkg::IDX_3: lcr_next   = wr_data;
               urbd_pkg::IDX_4: resume_char_one_next  = wr_data;
               urbd_pkg::IDX_5: resume_char_two_next  = wr_data;
               urbd_pkg::IDX_6: pause_char_one_next = wr_data;
               urbd_pkg::IDX_7: pause_char_two_next = wr_data;
            endcase
         end else begin
            unique case (addr)
               urbd_pkg::IDX_0: begin
                  if (div_sel) begin
                     div_lo_next = wr_data;
                  end else begin
                     thr_next     = wr_data;
                     thr_stb_next = 1'b1;
                  end
               end
               urbd_pkg::IDX_1: begin
                  if (div_sel)
                     div_hi_next = wr_data;
                  else
                     imask_next  = wr_data;
               end
               urbd_pkg::IDX_2: begin
                  if (div_sel && efr_on)
                     dld_next = wr_data & urbd_pkg::DLD_MASK;
                  else if (div_sel)
                     afr_next = wr_data & urbd_pkg::AFR_MASK;
                  else
                     fcr_next = wr_data;
               end
               urbd_pkg::IDX_3: lcr_next = wr_data;
               urbd_pkg::IDX_4: mcr_next = wr_data;
               // read-only spots swallow writes
               urbd_pkg::IDX_5, urbd_pkg::IDX_6, urbd_pkg::IDX_7: ;
            endcase
         end
      end
   end

   // transmit-ready latch: set on empty or on enabling while empty
   always_comb begin
      txi_next = txi_reg;
      if (rd_isr || thr_stb_next)
         txi_next = 1'b0;
      if ((tx_empty && !txi_reg && !thr_stb_reg && !rd_isr
           && !thr_stb_next)
          || (imask_next[urbd_pkg::IM_TX] && !imask_reg[urbd_pkg::IM_TX]
              && tx_empty))
         txi_next = 1'b1;
   end

   // read mux; reserved bits read zero, write-only spots return receive data, status or fifo level
   always_comb begin
      rdata_next   = rdata_reg;
      rhr_ack_next = 1'b0;
      if (rd_stb) begin
         rdata_next = urbd_pkg::ZERO8;
         if (enh_sel) begin
            unique case (addr)
               urbd_pkg::IDX_0: rdata_next = fifo_level;
               urbd_pkg::IDX_1: rdata_next = feature_control_reg;
               urbd_pkg::IDX_2: rdata_next = efr_reg;
               urbd_pkg::IDX_3: rdata_next = lcr_reg;
               urbd_pkg::IDX_4: rdata_next = resume_char_one_reg;
               urbd_pkg::IDX_5: rdata_next = resume_char_two_reg;
               urbd_pkg::IDX_6: rdata_next = pause_char_one_reg;
               urbd_pkg::IDX_7: rdata_next = pause_char_two_reg;
            endcase
         end else begin
            unique case (addr)
               urbd_pkg::IDX_0: begin
                  if (div_sel) begin
                     rdata_next = div_lo_reg;
                  end else begin
                     rdata_next   = rx_char;
                     rhr_ack_next = 1'b1;
                  end
               end
               urbd_pkg::IDX_1:
                  rdata_next = div_sel ? div_hi_reg : c.mask;
               urbd_pkg::IDX_2: begin
                  if (div_sel && efr_on)
                     rdata_next = dld_reg;
                  else if (div_sel)
                     rdata_next = afr_reg;
                  else
                     rdata_next = c.source;
               end
               urbd_pkg::IDX_3: rdata_next = lcr_reg;
               urbd_pkg::IDX_4: rdata_next = mcr_reg;
               urbd_pkg::IDX_5: rdata_next = line_status_reg;
               urbd_pkg::IDX_6: rdata_next = modem_status;
               urbd_pkg::IDX_7: rdata_next = scratch_in;
            endcase
         end
      end
   end

   // identity registers overlay when both divisor bytes are zero
   logic [7:0] rd_final;
   always_comb begin
      rd_final = rdata_next;
      if (rd_stb && div_sel && !enh_sel && div_lo_reg == urbd_pkg::ZERO8
          && div_hi_reg == urbd_pkg::ZERO8) begin
         if (addr == urbd_pkg::IDX_0)
            rd_final = REV_CODE;
         else if (addr == urbd_pkg::IDX_1)
            rd_final = ID_CODE;
      end
   end

   // interrupt line high when any enabled source pends
   always_comb begin
      int_next = (c.source[5:0] != urbd_pkg::SRC_NONE);
   end

   // state registers
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         div_lo_reg  <= urbd_pkg::ZERO8;
         div_hi_reg  <= urbd_pkg::ZERO8;
         lcr_reg     <= urbd_pkg::ZERO8;
         efr_reg     <= urbd_pkg::ZERO8;
         imask_reg   <= urbd_pkg::ZERO8;
         afr_reg     <= urbd_pkg::ZERO8;
         dld_reg     <= urbd_pkg::ZERO8;
         feature_control_reg    <= urbd_pkg::ZERO8;
         resume_char_one_reg    <= urbd_pkg::ZERO8;
         resume_char_two_reg    <= urbd_pkg::ZERO8;
         pause_char_one_reg   <= urbd_pkg::ZERO8;
         pause_char_two_reg   <= urbd_pkg::ZERO8;
         trg_reg     <= urbd_pkg::ZERO8;
         fcr_reg     <= urbd_pkg::ZERO8;
         mcr_reg     <= urbd_pkg::ZERO8;
         thr_reg     <= urbd_pkg::ZERO8;
         rdata_reg   <= urbd_pkg::ZERO8;
         thr_stb_reg <= 1'b0;
         rhr_ack_reg <= 1'b0;
         trg_stb_reg <= 1'b0;
         txi_reg     <= 1'b0;
         int_reg     <= 1'b0;
      end else begin
         div_lo_reg  <= div_lo_next;
         div_hi_reg  <= div_hi_next;
         lcr_reg     <= lcr_next;
         efr_reg     <= efr_next;
         imask_reg   <= imask_next;
         afr_reg     <= afr_next;
         dld_reg     <= dld_next;
         feature_control_reg    <= feature_control_next;
         resume_char_one_reg    <= resume_char_one_next;
         resume_char_two_reg    <= resume_char_two_next;
         pause_char_one_reg   <= pause_char_one_next;
         pause_char_two_reg   <= pause_char_two_next;
         trg_reg     <= trg_next;
         fcr_reg     <= fcr_next;
         mcr_reg     <= mcr_next;
         thr_reg     <= thr_next;
         rdata_reg   <= rd_final;
         thr_stb_reg <= thr_stb_next;
         rhr_ack_reg <= rhr_ack_next;
         trg_stb_reg <= trg_stb_next;
         txi_reg     <= txi_next;
         int_reg     <= int_next;
      end
   end

   // every output straight from a flip-flop
   assign rd_data          = rdata_reg;
   assign tx_char_stb      = thr_stb_reg;
   assign tx_char          = thr_reg;
   assign rx_char_ack      = rhr_ack_reg;
   assign int_out          = int_reg;
   assign divisor_out      = div_lo_reg;
   assign divisor_hi_out   = div_hi_reg;
   assign line_control_out = lcr_reg;
   assign enhanced_out     = efr_reg;
   assign mask_out         = imask_reg;
   assign trigger_out      = trg_reg;
   assign trigger_stb      = trg_stb_reg;
   assign fcr_out          = fcr_reg;
   assign mcr_out          = mcr_reg;
endmodule : urbd_bank

/* File: urbd_bank_properties.sv */
/*
 concurrent checks on the register bank ports, bound to urbd_bank.
 assumes one clock and the asynchronous active-low reset.
*/
`timescale 1ns/1ps
module urbd_bank_props (
   input wire logic       sys_clk,
   input wire logic       arst_n,
   input wire logic [2:0] addr,
   input wire logic       rd_stb,
   input wire logic       wr_stb,
   input wire logic [7:0] wr_data,
   input wire logic [7:0] rd_data,
   input wire logic       tx_char_stb,
   input wire logic [7:0] tx_char,
   input wire logic       rx_char_ack,
   input wire logic [7:0] rx_char,
   input wire logic       rx_avail,
   input wire logic [7:0] line_status_reg,
   input wire logic       int_out,
   input wire logic [7:0] divisor_out,
   input wire logic [7:0] divisor_hi_out,
   input wire logic [7:0] line_control_out,
   input wire logic [7:0] enhanced_out,
   input wire logic [7:0] mask_out,
   input wire logic [7:0] fcr_out,
   input wire logic [7:0] trigger_out,
   input wire logic       trigger_stb
);
   logic norm;
   logic div;
   // map selection as seen from the registered line control copy
   assign norm = !line_control_out[7];
   assign div  = line_control_out[7] && (line_control_out != 8'hbf);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   property p_thr;
      wr_stb && addr == 3'h0 && norm |=>
         tx_char_stb && tx_char == $past(wr_data);
   endproperty
   a_thr: assert property (p_thr)
      else $error("transmit write not passed on");
   property p_rhr;
      rd_stb && addr == 3'h0 && norm |=>
         rx_char_ack && rd_data == $past(rx_char);
   endproperty
   a_rhr: assert property (p_rhr)
      else $error("receive read wrong");
   property p_rdnotx;
      rd_stb |=> !tx_char_stb;
   endproperty
   a_rdnotx: assert property (p_rdnotx)
      else $error("read caused a transmit");
   property p_dll;
      wr_stb && addr == 3'h0 && div |=> divisor_out == $past(wr_data);
   endproperty
   a_dll: assert property (p_dll)
      else $error("low divisor not written");
   property p_dlm;
      wr_stb && addr == 3'h1 && div |=> divisor_hi_out == $past(wr_data);
   endproperty
   a_dlm: assert property (p_dlm)
      else $error("high divisor not written");
   property p_msk;
      wr_stb && addr == 3'h1 && norm |=>
         mask_out[3:0] == $past(wr_data[3:0]);
   endproperty
   a_msk: assert property (p_msk)
      else $error("mask low bits not written");
   property p_hi0;
      rd_stb && addr == 3'h1 && norm && !enhanced_out[4] |=>
         rd_data[7:4] == 4'h0;
   endproperty
   a_hi0: assert property (p_hi0)
      else $error("upper mask bits visible");
   property p_off;
      (mask_out == 8'h00) [*3] |-> !int_out;
   endproperty
   a_off: assert property (p_off)
      else $error("interrupt while fully masked");
   property p_ls;
      (mask_out[2] && (|line_status_reg[4:1])) [*3] |-> int_out;
   endproperty
   a_ls: assert property (p_ls)
      else $error("line status interrupt missing");
   property p_rx;
      (mask_out[0] && rx_avail && !fcr_out[0]) [*3] |-> int_out;
   endproperty
   a_rx: assert property (p_rx)
      else $error("receive interrupt missing");
   property p_isr;
      rd_stb && addr == 3'h2 && norm |=> rd_data[0] == !int_out;
   endproperty
   a_isr: assert property (p_isr)
      else $error("status and interrupt line disagree");
   property p_trg;
      wr_stb && addr == 3'h0 && line_control_out == 8'hbf |=>
         trigger_stb && trigger_out == $past(wr_data);
   endproperty
   a_trg: assert property (p_trg)
      else $error("trigger write not passed on");
endmodule : urbd_bank_props

bind urbd_bank urbd_bank_props u_props (.sys_clk, .arst_n, .addr,
   .rd_stb, .wr_stb, .wr_data, .rd_data, .tx_char_stb, .tx_char,
   .rx_char_ack, .rx_char, .rx_avail, .line_status_reg, .int_out,
   .divisor_out, .divisor_hi_out, .line_control_out, .enhanced_out,
   .mask_out, .fcr_out, .trigger_out, .trigger_stb);

/* File: urbd_core_model.sv */
/*
 behavioural receiver/transmitter core facing the bank.
 assumes the bank's ack and transmit strobes are one-cycle pulses.
*/
`timescale 1ns/1ps
module urbd_core_model (
   input  wire logic       sys_clk,
   input  wire logic       arst_n,
   input  wire logic       rx_push,
   input  wire logic       rx_char_ack,
   input  wire logic       tx_char_stb,
   output logic      [7:0] rx_char,
   output logic            rx_avail,
   output logic            tx_empty
);
   int         cnt;
   int         busy;
   logic [7:0] head;
   // counting receive queue; the transmitter stays busy four cycles
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt <= 0;
         busy <= 0;
         head <= 8'h30;
      end else begin
         cnt <= cnt + int'(rx_push) - int'(rx_char_ack && cnt > 0);
         if (rx_char_ack && cnt > 0) head <= head + 8'h01;
         busy <= tx_char_stb ? 4 : (busy > 0 ? busy - 1 : 0);
      end
   end
   // an empty receiver shows the inverse, never a stale char
   assign rx_avail = cnt > 0;
   assign rx_char  = (cnt > 0) ? head : ~head;
   assign tx_empty = busy == 0;
endmodule : urbd_core_model

/* File: uart_register_bank_decode_tb_top.sv */
/*
 self-checking bench for the register bank with a core model.
 assumes 100 MHz sys_clk and the package in urbd_pkg.
*/
`timescale 1ns/1ps
module uart_register_bank_decode_tb_top;
   localparam logic [7:0] REV = 8'h3c;   // arbitrary value
   localparam logic [7:0] ID  = 8'ha7;   // arbitrary value
   logic       sys_clk, arst_n, rd_stb, wr_stb, rx_push;
   logic [2:0] addr;
   logic [7:0] wr_data, rd_data, tx_char, rx_char, line_status_reg;
   logic [7:0] modem_status, fifo_level, scratch_in, divisor_out, v;
   logic       tx_char_stb, rx_char_ack, rx_avail, tx_empty, int_out;
   logic [7:0] q[$];
   logic [7:0] exp_rx;
   logic       rx_trig_hit, rx_timeout, xoff_seen, flow_rise;
   logic [7:0] trg_o, mcr_o;
   int         fails, n_compared;
   urbd_bank #(.REV_CODE(REV), .ID_CODE(ID)) i_dut (.sys_clk, .arst_n,
      .addr, .rd_stb, .wr_stb, .wr_data, .rd_data, .tx_char_stb,
      .tx_char, .rx_char_ack, .rx_char, .rx_avail, .rx_trig_hit,
      .rx_timeout, .tx_empty, .line_status_reg, .modem_status,
      .xoff_seen, .flow_rise, .fifo_level, .scratch_in,
      .int_out, .divisor_out, .divisor_hi_out(), .line_control_out(),
      .enhanced_out(), .mask_out(), .trigger_out(trg_o), .trigger_stb(),
      .fcr_out(), .mcr_out(mcr_o));
   urbd_core_model i_core (.sys_clk, .arst_n, .rx_push, .rx_char_ack,
      .tx_char_stb, .rx_char, .rx_avail, .tx_empty);
   task chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      addr <= a;
      wr_data <= d;
      wr_stb <= 1'b1;
      @(posedge sys_clk);
      wr_stb <= 1'b0;
   endtask : wr
   // read answer is registered, so sample it mid-cycle after the take
   task rc(input logic [2:0] a, input logic [7:0] e);
      @(posedge sys_clk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge sys_clk);
      rd_stb <= 1'b0;
      @(negedge sys_clk);
      chk(rd_data, e);
   endtask : rc
   task end_sim;
      $display("compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : end_sim
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   // every accepted transmit char must match the model queue in order
   always @(posedge sys_clk) begin
      // a strobe with nothing queued is forced to mismatch
      if (tx_char_stb === 1'b1)
         chk(tx_char, q.size() > 0 ? q.pop_front() : ~tx_char);
   end
   // watchdog at 20000 cycles; the sequence needs well under 2000 cycles
   initial begin
      repeat (20000) @(posedge sys_clk);
      fails++;
      end_sim();
   end
   initial begin
      {arst_n, rd_stb, wr_stb, rx_push, addr, wr_data} = '0;
      {line_status_reg, scratch_in} = '0;
      {rx_trig_hit, rx_timeout, xoff_seen, flow_rise} = '0;
      v = 8'($urandom(72410));
      modem_status = 8'h00;
      fifo_level = 8'($urandom);
      exp_rx = 8'h30;
      repeat (16) @(posedge sys_clk);
      arst_n <= 1'b1;
      rc(3'h1, 8'h00);
      wr(3'h3, 8'h80);
      wr(3'h0, 8'h12);
      wr(3'h1, 8'h34);
      rc(3'h0, 8'h12);
      rc(3'h1, 8'h34);
      chk(divisor_out, 8'h12);
      wr(3'h0, 8'h00);
      wr(3'h1, 8'h00);
      rc(3'h0, REV);
      rc(3'h1, ID);
      v = 8'($urandom);
      wr(3'h2, v);
      rc(3'h2, v & 8'h07);
      // back-to-back transmit writes, then pop three received chars
      wr(3'h3, 8'h03);
      repeat (4) begin
         v = 8'($urandom);
         q.push_back(v);
         wr(3'h0, v);
      end
      @(posedge sys_clk);
      rx_push <= 1'b1;
      repeat (3) @(posedge sys_clk);
      rx_push <= 1'b0;
      repeat (3) begin
         rc(3'h0, exp_rx);
         exp_rx++;
      end
      repeat (4) begin
         v = 8'($urandom);
         wr(3'h1, v);
         rc(3'h1, v & 8'h0f);
      end
      wr(3'h3, 8'hbf);
      wr(3'h2, 8'h10);
      rc(3'h2, 8'h10);
      v = 8'($urandom);
      wr(3'h0, v);
      rc(3'h0, fifo_level);
      chk(trg_o, v);
      for (int i = 4; i < 8; i++) begin
         v = 8'($urandom);
         wr(3'(i), v);
         rc(3'(i), v);
      end
      rc(3'h3, 8'hbf);
      wr(3'h3, 8'h80);
      v = 8'($urandom);
      wr(3'h2, v);
      rc(3'h2, v & 8'h0f);
      wr(3'h3, 8'h03);
      wr(3'h1, 8'hf0);
      rc(3'h1, 8'hf0);
      wr(3'h1, 8'h00);
      rc(3'h2, {2'b00, urbd_pkg::SRC_NONE});
      wr(3'h1, 8'h02);
      rc(3'h2, {2'b00, urbd_pkg::SRC_TX});
      @(posedge sys_clk);
      line_status_reg <= 8'h02;
      wr(3'h1, 8'h06);
      rc(3'h2, {2'b00, urbd_pkg::SRC_LS});
      rc(3'h5, 8'h02);
      @(posedge sys_clk);
      line_status_reg <= 8'h00;
      rx_push <= 1'b1;
      @(posedge sys_clk);
      rx_push <= 1'b0;
      wr(3'h1, 8'h01);
      rc(3'h2, {2'b00, urbd_pkg::SRC_RX});
      // fifo mode: trigger, timeout, modem, xoff and flow sources
      wr(3'h2, 8'h01);
      rx_trig_hit <= 1'b1;
      rc(3'h2, {2'b11, urbd_pkg::SRC_RX});
      @(posedge sys_clk);
      rx_timeout <= 1'b1;
      rc(3'h2, {2'b11, urbd_pkg::SRC_RXTO});
      @(posedge sys_clk);
      {rx_trig_hit, rx_timeout, modem_status} <= {2'b00, 8'h01};
      wr(3'h1, 8'h08);
      rc(3'h2, {2'b11, urbd_pkg::SRC_MS});
      @(posedge sys_clk);
      {modem_status, xoff_seen} <= {8'h00, 1'b1};
      wr(3'h1, 8'h20);
      rc(3'h2, {2'b11, urbd_pkg::SRC_XOFF});
      @(posedge sys_clk);
      {xoff_seen, flow_rise} <= 2'b01;
      wr(3'h1, 8'h80);
      rc(3'h2, {2'b11, urbd_pkg::SRC_FLOW});
      wr(3'h1, 8'h00);
      rc(3'h2, {2'b11, urbd_pkg::SRC_NONE});
      @(posedge sys_clk);
      v = 8'($urandom);
      scratch_in <= v;
      rc(3'h7, v);
      wr(3'h7, ~v);
      rc(3'h7, v);
      v = 8'($urandom);
      wr(3'h4, v);
      rc(3'h4, v);
      chk(mcr_o, v);
      chk(8'(q.size()), 8'h00);
      end_sim();
   end
endmodule : uart_register_bank_decode_tb_top
